//--- core/ufx_uart_tx.sv
// frame formatter, transmit buffer and shifter with apb register slave
// assumes one 250 mhz clock, apb master on the same clock
`timescale 1ns/1ns
`include "ufx_defs.svh"
module ufx_uart_tx #(
  parameter int DIV_W = 8
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  output logic             tx_out,
  output logic             tx_oe_out,
  output logic             rx_in_use_out,
  output logic             tx_irq_req_out
);
  import ufx_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]       line_ctrl;
  logic [7:0]       port_ctrl;
  logic [DIV_W-1:0] baud_divisor;
  logic [7:0]       data_buffer;
  logic             buf_full;
  logic             transmit_empty_flag;
  logic             transmit_idle_flag;
  logic             status_armed;
  logic [8:0]       transmit_shifter;
  logic [3:0]       bit_idx;
  logic [14:0]      baud_cnt;
  logic [9:0]       hold_cnt;
  logic             brk_armed;
  ufx_state_t       state;
  ufx_state_t       next_state;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire word9      = line_ctrl[`UFX_LC_WORD9];
  wire par_en     = line_ctrl[`UFX_LC_PAR_EN];
  wire par_odd    = line_ctrl[`UFX_LC_PAR_ODD];
  wire stop2      = line_ctrl[`UFX_LC_STOP2];
  wire ninth      = line_ctrl[`UFX_LC_NINTH];
  wire port_en    = line_ctrl[`UFX_LC_PORT_EN];
  wire send_break = port_ctrl[`UFX_PC_BREAK];
  wire tx_en      = port_ctrl[`UFX_PC_TX_EN];
  wire rx_en      = port_ctrl[`UFX_PC_RX_EN];
  wire transmit_empty_irq_enable       = port_ctrl[`UFX_PC_TRANSMIT_EMPTY_IRQ_ENABLE];
  wire hispeed    = port_ctrl[`UFX_PC_HISPEED];
  wire run        = port_en & tx_en;

  wire acc        = psel_in & penable_in & pready_out;
  wire wr         = acc & pwrite_in;
  wire sel_lc     = paddr_in == `UFX_OFS_LINE_CTRL;
  wire sel_pc     = paddr_in == `UFX_OFS_PORT_CTRL;
  wire sel_st     = paddr_in == `UFX_OFS_STATUS;
  wire sel_dt     = paddr_in == `UFX_OFS_DATA;
  wire sel_dv     = paddr_in == `UFX_OFS_DIVISOR;
  wire mapped     = sel_lc | sel_pc | sel_st | sel_dt | sel_dv;
  wire data_wr    = wr & sel_dt & transmit_empty_flag;
  wire clr_seq    = data_wr & status_armed;

  // ---------------------------------------------------------------
  // baud generator
  // ---------------------------------------------------------------
  wire [14:0] div_p1 = {{(15-DIV_W){1'b0}}, baud_divisor} + 15'h0001;
  wire [3:0]  shamt  = hispeed ? `UFX_HI_SHIFT : `UFX_LO_SHIFT;
  wire [14:0] period = div_p1 << shamt;
  wire        bit_tick = (state != UFX_IDLE) && (baud_cnt == period - 15'h0001);

  // ---------------------------------------------------------------
  // frame building
  // ---------------------------------------------------------------
  // idle write goes straight to the shifter, so frame it from the bus word
  wire [7:0] src_byte = (state == UFX_IDLE && run && data_wr) ? pwdata_in[7:0] : data_buffer;
  wire [7:0] pay8    = word9 ? src_byte : {1'b0, src_byte[6:0]};
  wire       par_bit = (^pay8) ^ par_odd;
  wire       top8    = par_en ? par_bit : src_byte[7];
  wire       top9    = par_en ? par_bit : ninth;
  wire [8:0] frame   = word9 ? {top9, src_byte} :
                               {1'b0, top8, src_byte[6:0]};
  wire [3:0] last_data = word9 ? 4'h8 : 4'h7;
  wire [3:0] last_stop = stop2 ? 4'h1 : 4'h0;

  wire idle_now   = state == UFX_IDLE;
  wire stop_done  = (state == UFX_STOP) && bit_tick && (bit_idx >= last_stop);
  wire free_slot  = idle_now | stop_done;
  wire brk_go     = free_slot & run & brk_armed;
  wire direct_ld  = idle_now & run & data_wr & ~brk_armed;
  wire buf_ld     = free_slot & run & buf_full & ~brk_armed;
  wire frame_go   = direct_ld | buf_ld | brk_go;
  wire brk_end    = (state == UFX_BRK) && bit_tick && (bit_idx == `UFX_BREAK_BITS - 4'h1);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      UFX_IDLE: begin
        if (frame_go) begin
          next_state = UFX_START;
        end
      end
      UFX_START: begin
        if (bit_tick) begin
          next_state = brk_armed ? UFX_BRK : UFX_DATA;
        end
      end
      UFX_DATA: begin
        if (bit_tick && bit_idx >= last_data) begin
          next_state = UFX_STOP;
        end
      end
      UFX_STOP: begin
        if (stop_done) begin
          next_state = frame_go ? UFX_START : UFX_IDLE;
        end
      end
      UFX_BRK: begin
        if (brk_end && !send_break) begin
          next_state = UFX_STOP;
        end
      end
      default: next_state = UFX_IDLE;
    endcase
    if (!run) begin
      next_state = UFX_IDLE;
    end
  end

  wire state_chg = next_state != state;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state    <= UFX_IDLE;
      bit_idx  <= 4'h0;
      baud_cnt <= 15'h0000;
    end else begin
      state    <= next_state;
      bit_idx  <= (state_chg || brk_end) ? 4'h0 : bit_idx + {3'h0, bit_tick};
      baud_cnt <= (state_chg || bit_tick || idle_now) ? 15'h0000 : baud_cnt + 15'h0001;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      transmit_shifter <= 9'h1ff;
    end else if ((direct_ld || buf_ld) && frame_go) begin
      transmit_shifter <= frame;
    end else if (state == UFX_DATA && bit_tick) begin
      transmit_shifter <= {1'b1, transmit_shifter[8:1]};
    end
  end

  // ---------------------------------------------------------------
  // break hold detect
  // ---------------------------------------------------------------
  wire brk_hold = run & send_break & transmit_idle_flag & idle_now;
  wire brk_long = hold_cnt >= ({{(10-DIV_W){1'b0}}, baud_divisor} + `UFX_BRK_EXTRA);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_cnt  <= 10'h000;
      brk_armed <= 1'b0;
    end else begin
      hold_cnt  <= (brk_hold && !brk_long) ? hold_cnt + 10'h001 :
                   (brk_hold ? hold_cnt : 10'h000);
      brk_armed <= run & ((state == UFX_START && bit_tick) ? 1'b0 :
                          (brk_armed | (brk_hold & brk_long & ~frame_go)));
    end
  end

  // ---------------------------------------------------------------
  // buffer and flags
  // ---------------------------------------------------------------
  wire buf_take = data_wr & ~direct_ld;
  wire rd_status = acc & ~pwrite_in & sel_st;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_buffer         <= 8'h00;
      buf_full            <= 1'b0;
      transmit_empty_flag <= 1'b1;
      transmit_idle_flag  <= 1'b1;
      status_armed        <= 1'b0;
    end else if (!port_en) begin
      buf_full            <= 1'b0;
      transmit_empty_flag <= 1'b1;
      transmit_idle_flag  <= 1'b1;
      status_armed        <= 1'b0;
    end else begin
      if (data_wr) begin
        data_buffer <= pwdata_in[7:0];
      end
      buf_full <= buf_take | (buf_full & ~buf_ld);
      // set wins over the clearing write
      transmit_empty_flag <= buf_ld | direct_ld |
                             (transmit_empty_flag & ~(buf_take & clr_seq));
      transmit_idle_flag  <= stop_done | (transmit_idle_flag & ~clr_seq);
      status_armed        <= rd_status | (status_armed & ~data_wr);
    end
  end

  // ---------------------------------------------------------------
  // register slave
  // ---------------------------------------------------------------
  wire [7:0] status_val = {5'h00, 1'b1, transmit_idle_flag, transmit_empty_flag};
  wire [7:0] rd_val = sel_lc ? line_ctrl :
                      sel_pc ? port_ctrl :
                      sel_st ? status_val :
                      sel_dt ? data_buffer :
                      sel_dv ? baud_divisor[7:0] : 8'h00;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_ctrl    <= `UFX_RST_LINE_CTRL;
      port_ctrl    <= `UFX_RST_PORT_CTRL;
      baud_divisor <= `UFX_RST_DIVISOR;
    end else begin
      if (wr && sel_lc) begin
        line_ctrl <= pwdata_in[7:0];
      end
      if (wr && sel_dv) begin
        baud_divisor <= pwdata_in[DIV_W-1:0];
      end
      if (!port_en) begin
        port_ctrl <= port_ctrl & 8'h21;
      end else if (wr && sel_pc) begin
        port_ctrl <= pwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      prdata_out  <= {24'h000000, rd_val};
      pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  wire line_lvl = (state == UFX_START || state == UFX_BRK) ? 1'b0 :
                  (state == UFX_DATA) ? transmit_shifter[0] : 1'b1;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_out         <= 1'b1;
      tx_oe_out      <= 1'b0;
      rx_in_use_out  <= 1'b0;
      tx_irq_req_out <= 1'b0;
    end else begin
      tx_out         <= line_lvl;
      tx_oe_out      <= run;
      rx_in_use_out  <= port_en & rx_en;
      tx_irq_req_out <= transmit_empty_flag & transmit_empty_irq_enable & port_en &
                        (state != UFX_BRK) & ~brk_armed;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_idle_high;
    @(posedge clock_in) disable iff (!rst_n_in)
      state == UFX_IDLE |=> tx_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while idle");

  property p_start_low;
    @(posedge clock_in) disable iff (!rst_n_in)
      state == UFX_START |=> !tx_out;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_oe;
    @(posedge clock_in) disable iff (!rst_n_in)
      ##1 tx_oe_out == $past(port_en & tx_en);
  endproperty
  a_oe: assert property (p_oe) else $error("pin drive mismatch");

  property p_disable;
    @(posedge clock_in) disable iff (!rst_n_in)
      !port_en |=> transmit_empty_flag && transmit_idle_flag && !tx_en && !buf_full;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not reset flags");

  property p_abort;
    @(posedge clock_in) disable iff (!rst_n_in)
      !run |=> state == UFX_IDLE ##1 tx_out;
  endproperty
  a_abort: assert property (p_abort) else $error("frame not abandoned");

  property p_ignore;
    @(posedge clock_in) disable iff (!rst_n_in)
      wr && sel_dt && !transmit_empty_flag |=> $stable(data_buffer);
  endproperty
  a_ignore: assert property (p_ignore) else $error("write taken while full");

  property p_direct;
    @(posedge clock_in) disable iff (!rst_n_in)
      direct_ld |=> state == UFX_START && transmit_empty_flag;
  endproperty
  a_direct: assert property (p_direct) else $error("idle write did not start");

  property p_transmit_idle_flag;
    @(posedge clock_in) disable iff (!rst_n_in)
      stop_done && port_en |=> transmit_idle_flag;
  endproperty
  a_transmit_idle_flag: assert property (p_transmit_idle_flag) else $error("idle flag not set");

  property p_brk_irq;
    @(posedge clock_in) disable iff (!rst_n_in)
      state == UFX_BRK |=> !tx_irq_req_out;
  endproperty
  a_brk_irq: assert property (p_brk_irq) else $error("request during break");

  property p_reload;
    @(posedge clock_in) disable iff (!rst_n_in)
      buf_ld |=> state == UFX_START && transmit_empty_flag;
  endproperty
  a_reload: assert property (p_reload) else $error("buffer not reloaded");

  property p_brk_low;
    @(posedge clock_in) disable iff (!rst_n_in)
      state == UFX_BRK |=> !tx_out;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break bit not low");

  c_frame: cover property (@(posedge clock_in) disable iff (!rst_n_in) stop_done);
  c_break: cover property (@(posedge clock_in) disable iff (!rst_n_in) brk_end);
  c_reload: cover property (@(posedge clock_in) disable iff (!rst_n_in) stop_done && buf_ld);
endmodule

//--- core/ufx_defs.svh
// constants of the serial transmitter: offsets, field positions, reset values
// assumes inclusion by the transmitter module and the bench only
//
// Overview of operation
// - a frame is start bit, eight or nine data bits, one or two stop_count_select
// - after reset the format is eight data bits, no parity, one stop
// - parity is off, even or odd via enable and type controls
// - one shared format and 8-bit baud divisor; bits go out lsb first
// - the line sits high whenever no frame is being sent
// - port, transmit and receive enabled: drive transmit pin, use receive pin
// - disabling empties the buffer, clears transmit and receive enables and flags, sets idle flags
// - disabling aborts activity at once; re-enabling keeps the configuration
// - stop count choice affects only the transmitter; receiver checks one
// - field of 8 or 9 bits; top position may carry parity or address
// - in nine-bit mode without parity the top bit comes from a dedicated control bit
// - shifter reloads from buffer after the stop bits or while idle, if buffer full
// - sending starts only with enable and data, loaded in either order
// - clearing transmit enable mid-frame stop_count_select at once and resets transmitter
// - buffer writes are ignored while the empty flag is low
// - status access then buffer write clears empty and idle flags
// - empty flag set when buffer can take a word; enabled raises a request
// - write during a frame waits; write while idle loads shifter directly
// - idle flag set when a frame finishes, after stop_count_select or after a break
// - break held over divisor+1 cycles while idle makes next frame a break
// - breaks repeat while held; after release finish break then send stop_count_select
// - sending a break raises no transmit request
// - bit time is 64 or 16 times divisor plus one port clocks
`ifndef UFX_DEFS_SVH
`define UFX_DEFS_SVH
`define UFX_OFS_LINE_CTRL   12'h000
`define UFX_OFS_PORT_CTRL   12'h004
`define UFX_OFS_STATUS      12'h008
`define UFX_OFS_DATA        12'h00c
`define UFX_OFS_DIVISOR     12'h010
// line control fields
`define UFX_LC_WORD9        0
`define UFX_LC_PAR_EN       1
`define UFX_LC_PAR_ODD      2
`define UFX_LC_STOP2        3
`define UFX_LC_NINTH        4
`define UFX_LC_PORT_EN      7
// port control fields
`define UFX_PC_TRANSMIT_EMPTY_IRQ_ENABLE         0
`define UFX_PC_BREAK        2
`define UFX_PC_HISPEED      5
`define UFX_PC_RX_EN        6
`define UFX_PC_TX_EN        7
// status fields
`define UFX_ST_TX_EMPTY     0
`define UFX_ST_TX_IDLE      1
`define UFX_ST_RX_IDLE      2
// reset values
`define UFX_RST_LINE_CTRL   8'h00
`define UFX_RST_PORT_CTRL   8'h00
`define UFX_RST_DIVISOR     8'h00
// timing counts
`define UFX_LO_SHIFT        4'h6
`define UFX_HI_SHIFT        4'h4
`define UFX_BREAK_BITS      4'hd
`define UFX_BRK_EXTRA       10'h002
`endif

//--- core/ufx_pkg.sv
// types of the serial transmitter
// assumes nothing beyond the constants header
package ufx_pkg;
  typedef enum logic [2:0] {
    UFX_IDLE,
    UFX_START,
    UFX_DATA,
    UFX_STOP,
    UFX_BRK
  } ufx_state_t;
endpackage

//--- bench/ufx_line_monitor.sv
// far-end receiver model sampling the serial line at bit centres
// assumes bit length and field width are set by the bench before each frame
`timescale 1ns/1ns
module ufx_line_monitor (
  input  wire logic        clock_in,
  input  wire logic        line_in,
  input  wire logic [15:0] bit_clks_in,
  input  wire logic [3:0]  field_bits_in,
  output logic [10:0]      word_out,
  output logic [15:0]      count_out
);
  initial begin
    word_out = '0;
    count_out = '0;
    forever begin
      @(negedge line_in);
      // start centre, then data lsb first and one stop only
      repeat (bit_clks_in / 2) @(posedge clock_in);
      word_out = '0;
      for (int i = 0; i <= field_bits_in; i++) begin
        repeat (bit_clks_in) @(posedge clock_in);
        word_out[i] = line_in;
      end
      count_out = count_out + 16'h0001;
    end
  end
endmodule

//--- bench/testbench.sv
// self-checking bench: apb register tasks and far-end line model
// assumes a 250 mhz clock and divisor 1 at high speed, 32 clocks a bit
`timescale 1ns/1ns
`include "ufx_defs.svh"
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [11:0] LC = `UFX_OFS_LINE_CTRL;
  localparam logic [11:0] PC = `UFX_OFS_PORT_CTRL;
  localparam logic [11:0] ST = `UFX_OFS_STATUS;
  localparam logic [11:0] DT = `UFX_OFS_DATA;
  localparam logic [11:0] DV = `UFX_OFS_DIVISOR;
  logic        clock_in = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        tx;
  logic        tx_oe;
  logic        rx_use;
  logic        irq;
  logic [3:0]  fbits = 4'h8;
  logic [10:0] word;
  logic [15:0] count;
  logic [15:0] c;
  logic [31:0] q;
  logic        err;
  int          n_fail = 0;
  int          total_checks = 0;
  int          run = 0;
  int          last_run = 0;
  logic [7:0]  fmt_lc [6] = '{8'h80, 8'h82, 8'h86, 8'h91, 8'h83, 8'h88};
  logic [7:0]  fmt_d [6] = '{8'ha5, 8'h53, 8'h53, 8'h3c, 8'h07, 8'hff};

  always #2 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (tx === 1'b0) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
  end

  ufx_uart_tx #(.DIV_W(8)) u_dut (
    .clock_in(clock_in), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .tx_out(tx), .tx_oe_out(tx_oe),
    .rx_in_use_out(rx_use), .tx_irq_req_out(irq));
  ufx_line_monitor u_far (
    .clock_in(clock_in), .line_in(tx), .bit_clks_in(16'd32), .field_bits_in(fbits),
    .word_out(word), .count_out(count));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock_in);
    penable <= 1'b1;
    n = 0;
    @(posedge clock_in);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 100) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask

  task automatic send(input logic [7:0] d);
    apb(1'b0, ST, 8'h00);
    wr(DT, d);
  endtask

  task automatic wait_frame(input logic [15:0] c0);
    int n;
    n = 0;
    while (count === c0 && n < 2000) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 2000) n_fail++;
  endtask

  function automatic logic [10:0] expect_word(input logic [7:0] lc, input logic [7:0] d);
    logic p;
    p = lc[`UFX_LC_PAR_ODD];
    if (lc[`UFX_LC_WORD9]) begin
      p = lc[`UFX_LC_PAR_EN] ? (^d ^ p) : lc[`UFX_LC_NINTH];
      return {2'b01, p, d};
    end
    if (lc[`UFX_LC_PAR_EN]) return {3'b001, ^d[6:0] ^ p, d[6:0]};
    return {3'b001, d};
  endfunction

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (60000) @(posedge clock_in);
    n_fail++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clock_in);
    rst_n <= 1'b1;
    @(posedge clock_in);
    chk(32'(tx), 32'h1);
    chk(32'(tx_oe), 32'h0);
    rdchk(LC, 32'h0);
    rdchk(PC, 32'h0);
    rdchk(ST, 32'h7);
    rdchk(DV, 32'h0);
    rdchk(12'h014, 32'h0);
    chk(32'(err), 32'h1);
    wr(DV, 8'h01);
    wr(LC, 8'h80);
    wr(PC, 8'he1);
    @(posedge clock_in);
    chk(32'(tx_oe & rx_use), 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(LC, fmt_lc[i]);
      fbits <= fmt_lc[i][0] ? 4'h9 : 4'h8;
      c = count;
      send(fmt_d[i]);
      rdchk(ST, 32'h5);
      wait_frame(c);
      chk(32'(word), 32'(expect_word(fmt_lc[i], fmt_d[i])));
      repeat (32) @(posedge clock_in);
      rdchk(ST, fmt_lc[i][3] ? 32'h5 : 32'h7);
    end
    wr(LC, 8'h80);
    fbits <= 4'h8;
    repeat (64) @(posedge clock_in);
    c = count;
    send(8'h11);
    send(8'h22);
    rdchk(ST, 32'h4);
    chk(32'(irq), 32'h0);
    wr(DT, 8'h33);
    wait_frame(c);
    chk(32'(word), 32'(expect_word(8'h80, 8'h11)));
    c = count;
    wait_frame(c);
    chk(32'(word), 32'(expect_word(8'h80, 8'h22)));
    c = count;
    repeat (400) @(posedge clock_in);
    chk(32'(count), 32'(c));
    chk(32'(irq), 32'h1);
    send(8'h00);
    repeat (40) @(posedge clock_in);
    wr(PC, 8'h61);
    repeat (2) @(posedge clock_in);
    chk(32'(tx), 32'h1);
    chk(32'(tx_oe), 32'h0);
    repeat (400) @(posedge clock_in);
    c = count;
    send(8'h4d);
    repeat (100) @(posedge clock_in);
    chk(32'(count), 32'(c));
    wr(PC, 8'he1);
    wait_frame(c);
    chk(32'(word), 32'(expect_word(8'h80, 8'h4d)));
    repeat (64) @(posedge clock_in);
    wr(PC, 8'he5);
    c = 16'h0;
    while (tx !== 1'b0 && c < 16'd500) begin
      @(posedge clock_in);
      c++;
    end
    chk(32'(irq), 32'h0);
    wr(PC, 8'he1);
    repeat (600) @(posedge clock_in);
    chk(32'(last_run), 32'd448);
    rdchk(ST, 32'h7);
    c = count;
    send(8'h5a);
    send(8'h5b);
    wr(LC, 8'h00);
    repeat (2) @(posedge clock_in);
    chk(32'(tx), 32'h1);
    rdchk(ST, 32'h7);
    rdchk(PC, 32'h21);
    wr(LC, 8'h80);
    rdchk(DV, 32'h1);
    wr(PC, 8'he1);
    repeat (400) @(posedge clock_in);
    c = count;
    send(8'h6e);
    wait_frame(c);
    chk(32'(word), 32'(expect_word(8'h80, 8'h6e)));
    final_report();
  end
endmodule
